// ==== rtl/vsm_core.sv ====
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// [RQ1] Four sample rates: 4.0/5.3/6.4/8.0 kHz
// [RQ2] Page 2048 bits, 32 blocks of 64
// [RQ3] Analog start set by 11-bit page address
// [RQ4] Eight end markers, one per 4 blocks
// [RQ5] Stop finishes group, then writes marker
// [RQ6] Stored marker in playback raises interrupt
// [RQ7] End resolution one four-block group
// [RQ8] Serial write data into 64-bit buffer
// [RQ9] Full buffer swaps with draining buffer
// [RQ10] Accept and acknowledge each byte
// [RQ11] Ack, then hold clock low when full
// [RQ12] Reads through two alternating 64-bit buffers
// [RQ13] Answer bus address 100 00xy from pins
// [RQ14] Address LSB selects transfer direction
// [RQ15] Host uses bytes 80-87 hex
// [RQ16] Density strap selects 256 to 2048 pages
// [RQ17] Opcode fixes page analog or digital
// [RQ18] Two 16-bit configuration registers
// [RQ19] Interrupt low until status read
// [RQ20] Row strobe low in last page block
// [RQ21] Status, address high, low; A[4:0] zero
// [RQ22] Release stretch once a buffer frees
module vsm_core #(
  parameter int P_DIV_4K0 = vsm_pkg::DIV_4K0,
  parameter int P_DIV_5K3 = vsm_pkg::DIV_5K3
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic i_addr_select_high,
  input wire logic i_addr_select_low,
  input wire logic [1:0] i_density,
  output logic o_int,
  output logic o_int_oe,
  output logic o_row_boundary_strobe,
  output logic o_row_boundary_strobe_oe,
  output logic [10:0] o_arr_page,
  output logic [4:0] o_arr_blk,
  output logic o_arr_wr_valid,
  output logic [63:0] o_arr_wr_data,
  input wire logic i_arr_wr_done,
  output logic o_arr_rd_req,
  input wire logic i_arr_rd_valid,
  input wire logic [63:0] i_arr_rd_data,
  input wire logic i_end_of_message_marker,
  output logic o_end_of_message_marker_wr,
  output logic o_erase_req,
  output logic o_power_up,
  output logic o_rec,
  output logic o_play,
  output logic [15:0] o_cfg0,
  output logic [15:0] o_cfg1
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
  logic [3:0] pin_m_r, pin_s_r;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  // Two flops per pin; third stage only for edge finding
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
      {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
      pin_m_r <= 4'h0;
      pin_s_r <= 4'h0;
    end else if (i_ce) begin
      {scl_m_r, scl_s_r, scl_d_r} <= {i_scl, scl_m_r, scl_s_r};
      {sda_m_r, sda_s_r, sda_d_r} <= {i_sda, sda_m_r, sda_s_r};
      pin_m_r <= {i_density, i_addr_select_high, i_addr_select_low};
      pin_s_r <= pin_m_r;
    end
  end

  assign scl_rise = scl_s_r & ~scl_d_r;
  assign scl_fall = ~scl_s_r & scl_d_r;
  assign bus_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign bus_stop = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  // ****************************************
  // Shared state and events
  // ****************************************
  vsm_pkg::vsm_st_t st_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r, tx_r;
  logic sda_oe_r, hold_r, rw_r;
  logic [1:0] ridx_r, bidx_r;
  logic [7:0] cmd_r, hi_r;
  logic [15:0] cfg0_r, cfg1_r;
  logic pwr_r, dig_r, rec_r, play_r, stop_pend_r, dwr_r, drd_r, erase_r;
  logic [10:0] page_r, last_page;
  logic [4:0] blk_r;
  logic [63:0] buf_r [2];
  logic wsel_r, rsel_r, need_swap_r;
  logic [2:0] wcnt_r, rcnt_r;
  logic [1:0] pend_r, rvalid_r;
  logic int_mark_r, int_ovf_r;
  logic [12:0] div_cnt_r, div_m1;
  logic [5:0] spb_r;
  logic addr_match, rx_ev, exec_ev, tx_ready, tx_take, status_clr;
  logic [7:0] ecmd, tx_byte, status;
  logic [15:0] eval;
  logic running, blk_tick, grp_end, mark_stop, mark_play, adv, wrap_ovf;
  logic analog_end, wr_take, fidx;

  assign addr_match = sh_r[7:1] ==
    {vsm_pkg::BUS_ADDR_TOP, pin_s_r[1], pin_s_r[0]}; // RQ13 RQ15
  assign rx_ev = scl_fall && st_r == vsm_pkg::S_RX &&
    cnt_r == vsm_pkg::BITS_PER_BYTE;
  assign ecmd = (bidx_r == vsm_pkg::BI_CMD) ? sh_r : cmd_r;
  assign eval = {hi_r, sh_r};
  assign exec_ev = rx_ev && ((bidx_r == vsm_pkg::BI_CMD &&
    sh_r[2:0] == vsm_pkg::RG_NONE) || bidx_r == vsm_pkg::BI_LO);
  assign status = {int_ovf_r, int_mark_r, play_r, rec_r, dig_r, pwr_r,
    2'h0};
  assign tx_ready = ~drd_r | rvalid_r[rsel_r];
  assign tx_take = st_r == vsm_pkg::S_TXW && tx_ready;
  assign status_clr = tx_take && !drd_r && ridx_r == vsm_pkg::RI_STAT;

  // Byte to send: array data, or status then address
  always_comb begin
    if (drd_r) begin
      tx_byte = buf_r[rsel_r][63:56]; // RQ12
    end else begin
      case (ridx_r)
        vsm_pkg::RI_STAT: tx_byte = status; // RQ21
        vsm_pkg::RI_AHI: tx_byte = page_r[10:3];
        vsm_pkg::RI_ALO: tx_byte = {page_r[2:0], vsm_pkg::ADDR_LOW_ZERO};
        default: tx_byte = 8'h00;
      endcase
    end
  end

  // ****************************************
  // Serial bus slave
  // ****************************************
  // Stretch flop lags one cycle; bus low time easily covers it
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      st_r <= vsm_pkg::S_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      sda_oe_r <= 1'b0;
      hold_r <= 1'b0;
      rw_r <= 1'b0;
      ridx_r <= vsm_pkg::RI_STAT;
    end else if (i_ce) begin
      if (bus_start) begin
        st_r <= vsm_pkg::S_ADDR;
        cnt_r <= 4'h0;
        sda_oe_r <= 1'b0;
        hold_r <= 1'b0;
      end else if (bus_stop) begin
        st_r <= vsm_pkg::S_IDLE;
        sda_oe_r <= 1'b0;
        hold_r <= 1'b0;
      end else begin
        case (st_r)
          vsm_pkg::S_ADDR, vsm_pkg::S_RX: begin
            if (scl_rise && cnt_r != vsm_pkg::BITS_PER_BYTE) begin
              sh_r <= {sh_r[6:0], sda_s_r};
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == vsm_pkg::BITS_PER_BYTE) begin
              cnt_r <= 4'h0;
              if (st_r == vsm_pkg::S_RX) begin
                sda_oe_r <= 1'b1; // RQ10
                st_r <= vsm_pkg::S_RXACK;
              end else if (addr_match) begin
                sda_oe_r <= 1'b1;
                rw_r <= sh_r[0]; // RQ14
                ridx_r <= vsm_pkg::RI_STAT;
                st_r <= vsm_pkg::S_AACK;
              end else begin
                st_r <= vsm_pkg::S_IDLE;
              end
            end
          end
          vsm_pkg::S_AACK: begin
            if (scl_fall) begin
              sda_oe_r <= 1'b0;
              st_r <= rw_r ? vsm_pkg::S_TXW : vsm_pkg::S_RX; // RQ14
            end
          end
          vsm_pkg::S_RXACK: begin
            if (scl_fall) begin
              sda_oe_r <= 1'b0;
              hold_r <= need_swap_r; // RQ11
              st_r <= need_swap_r ? vsm_pkg::S_RXW : vsm_pkg::S_RX;
            end
          end
          vsm_pkg::S_RXW: begin
            if (!need_swap_r) begin
              hold_r <= 1'b0; // RQ22
              st_r <= vsm_pkg::S_RX;
            end
          end
          vsm_pkg::S_TXW: begin
            if (tx_ready) begin
              sda_oe_r <= ~tx_byte[7];
              tx_r <= {tx_byte[6:0], 1'b0};
              cnt_r <= 4'h1;
              if (ridx_r != vsm_pkg::RI_END) begin
                ridx_r <= ridx_r + 2'h1;
              end
              st_r <= vsm_pkg::S_TX;
            end else begin
              hold_r <= 1'b1;
            end
          end
          vsm_pkg::S_TX: begin
            hold_r <= 1'b0;
            if (scl_fall) begin
              if (cnt_r == vsm_pkg::BITS_PER_BYTE) begin
                sda_oe_r <= 1'b0;
                cnt_r <= 4'h0;
                st_r <= vsm_pkg::S_TXACK;
              end else begin
                sda_oe_r <= ~tx_r[7];
                tx_r <= {tx_r[6:0], 1'b0};
                cnt_r <= cnt_r + 4'h1;
              end
            end
          end
          vsm_pkg::S_TXACK: begin
            if (scl_rise && sda_s_r) begin
              st_r <= vsm_pkg::S_IDLE;
            end else if (scl_fall) begin
              st_r <= vsm_pkg::S_TXW;
            end
          end
          default: st_r <= vsm_pkg::S_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Command parsing and modes
  // ****************************************
  // Byte slot: command, address high, address low, then data
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      bidx_r <= vsm_pkg::BI_CMD;
      cmd_r <= 8'h00;
      hi_r <= 8'h00;
    end else if (i_ce) begin
      if (bus_start) begin
        bidx_r <= vsm_pkg::BI_CMD;
      end else if (rx_ev) begin
        case (bidx_r)
          vsm_pkg::BI_CMD: begin
            cmd_r <= sh_r;
            bidx_r <= (sh_r[2:0] == vsm_pkg::RG_NONE) ?
              vsm_pkg::BI_DATA : vsm_pkg::BI_HI;
          end
          vsm_pkg::BI_HI: begin
            hi_r <= sh_r;
            bidx_r <= vsm_pkg::BI_LO;
          end
          vsm_pkg::BI_LO: bidx_r <= vsm_pkg::BI_DATA;
          default: bidx_r <= vsm_pkg::BI_DATA;
        endcase
      end
    end
  end

  // Analog or digital use follows the opcode that writes
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      {pwr_r, dig_r, rec_r, play_r, stop_pend_r} <= 5'h00;
      {dwr_r, drd_r, erase_r} <= 3'h0;
      cfg0_r <= 16'h0000;
      cfg1_r <= 16'h0000;
    end else if (i_ce) begin
      erase_r <= 1'b0;
      if (exec_ev) begin
        pwr_r <= ecmd[vsm_pkg::CMD_PU];
        if (ecmd[5:3] == vsm_pkg::FN_STOP &&
            ecmd[2:0] == vsm_pkg::RG_CFG0) begin
          cfg0_r <= eval; // RQ18
        end else if (ecmd[5:3] == vsm_pkg::FN_STOP &&
            ecmd[2:0] == vsm_pkg::RG_CFG1) begin
          cfg1_r <= eval; // RQ18
        end else if (!ecmd[vsm_pkg::CMD_DAB]) begin
          {dig_r, dwr_r, drd_r} <= 3'h0; // RQ17
          case (ecmd[5:3])
            vsm_pkg::FN_STOP: begin
              play_r <= 1'b0;
              stop_pend_r <= rec_r; // RQ5
            end
            vsm_pkg::FN_REC: begin
              {rec_r, play_r, stop_pend_r} <= 3'h4;
            end
            vsm_pkg::FN_PLAY, vsm_pkg::FN_CUE: begin
              {rec_r, play_r, stop_pend_r} <= 3'h2;
            end
            default: ;
          endcase
        end else begin
          dig_r <= ecmd[vsm_pkg::CMD_PU]; // RQ17
          {rec_r, play_r, stop_pend_r} <= 3'h0;
          case (ecmd[5:3])
            vsm_pkg::FN_DRD: {dwr_r, drd_r} <= 2'h1;
            vsm_pkg::FN_DWR: {dwr_r, drd_r} <= 2'h2;
            vsm_pkg::FN_ERASE: erase_r <= 1'b1;
            default: {dwr_r, drd_r} <= 2'h0;
          endcase
        end
      end
      if (analog_end) begin
        {rec_r, play_r, stop_pend_r} <= 3'h0;
      end
    end
  end

  // ****************************************
  // Analog timebase and page walk
  // ****************************************
  always_comb begin
    case (cfg1_r[1:0])
      vsm_pkg::RATE_8K0: div_m1 = 13'(vsm_pkg::DIV_8K0 - 1); // RQ1
      vsm_pkg::RATE_6K4: div_m1 = 13'(vsm_pkg::DIV_6K4 - 1);
      vsm_pkg::RATE_5K3: div_m1 = 13'(P_DIV_5K3 - 1);
      vsm_pkg::RATE_4K0: div_m1 = 13'(P_DIV_4K0 - 1);
      default: div_m1 = 13'(vsm_pkg::DIV_8K0 - 1);
    endcase
  end

  assign running = rec_r | play_r;
  assign blk_tick = running && div_cnt_r == div_m1 &&
    spb_r == vsm_pkg::BLK_SAMP_LAST;
  assign grp_end = blk_tick && blk_r[1:0] == vsm_pkg::GRP_LAST; // RQ4 RQ7
  assign mark_stop = grp_end & rec_r & stop_pend_r; // RQ5
  assign mark_play = grp_end & play_r & i_end_of_message_marker; // RQ6
  assign adv = blk_tick | i_arr_wr_done | i_arr_rd_valid;
  assign wrap_ovf = adv && blk_r == vsm_pkg::BLK_LAST &&
    page_r == last_page;
  assign analog_end = mark_stop | mark_play | wrap_ovf;
  assign last_page = 11'((vsm_pkg::PAGES_MIN << pin_s_r[3:2]) -
    12'h001); // RQ16

  // Sample and block counters run only while recording or playing
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      div_cnt_r <= 13'h0000;
      spb_r <= 6'h00;
    end else if (i_ce) begin
      if (!running || div_cnt_r == div_m1) begin
        div_cnt_r <= 13'h0000;
      end else begin
        div_cnt_r <= div_cnt_r + 13'h0001;
      end
      if (!running) begin
        spb_r <= 6'h00;
      end else if (div_cnt_r == div_m1) begin
        spb_r <= (spb_r == vsm_pkg::BLK_SAMP_LAST) ? 6'h00 :
          spb_r + 6'h01;
      end
    end
  end

  // Page and block address; A[4:0] of the bus view stays zero
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      page_r <= 11'h000;
      blk_r <= 5'h00;
    end else if (i_ce) begin
      if (exec_ev && ecmd[2:0] == vsm_pkg::RG_ADDR) begin
        page_r <= eval[15:5]; // RQ3
        blk_r <= 5'h00;
      end else if (adv) begin
        blk_r <= blk_r + 5'h01; // RQ2
        if (blk_r == vsm_pkg::BLK_LAST) begin
          page_r <= (page_r == last_page) ? 11'h000 : page_r + 11'h001;
        end
      end
    end
  end

  // ****************************************
  // Interrupt sources
  // ****************************************
  // A new event in the clearing cycle wins
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      int_mark_r <= 1'b0;
      int_ovf_r <= 1'b0;
    end else if (i_ce) begin
      if (status_clr) begin
        int_mark_r <= 1'b0; // RQ19
        int_ovf_r <= 1'b0;
      end
      if (mark_play) begin
        int_mark_r <= 1'b1; // RQ6
      end
      if (wrap_ovf) begin
        int_ovf_r <= 1'b1;
      end
    end
  end

  // ****************************************
  // Ping-pong data buffers
  // ****************************************
  assign wr_take = rx_ev && dwr_r && bidx_r == vsm_pkg::BI_DATA;
  assign fidx = rvalid_r[rsel_r] ? ~rsel_r : rsel_r;

  // Shared by write and read; modes never overlap
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      buf_r[0] <= 64'h0;
      buf_r[1] <= 64'h0;
      {wsel_r, rsel_r, need_swap_r} <= 3'h0;
      wcnt_r <= 3'h0;
      rcnt_r <= 3'h0;
      pend_r <= 2'h0;
      rvalid_r <= 2'h0;
    end else if (i_ce) begin
      if (exec_ev) begin
        rvalid_r <= 2'h0;
        rcnt_r <= 3'h0;
        wcnt_r <= 3'h0;
      end
      if (i_arr_wr_done) begin
        pend_r[~wsel_r] <= 1'b0;
      end
      if (wr_take) begin
        buf_r[wsel_r] <= {buf_r[wsel_r][55:0], sh_r}; // RQ8
        wcnt_r <= wcnt_r + 3'h1;
        if (wcnt_r == vsm_pkg::BYTE_LAST) begin
          pend_r[wsel_r] <= 1'b1;
          if (pend_r[~wsel_r] && !i_arr_wr_done) begin
            need_swap_r <= 1'b1; // RQ11
          end else begin
            wsel_r <= ~wsel_r; // RQ9
          end
        end
      end else if (need_swap_r && !pend_r[~wsel_r]) begin
        wsel_r <= ~wsel_r; // RQ22
        need_swap_r <= 1'b0;
      end
      if (i_arr_rd_valid && drd_r) begin
        buf_r[fidx] <= i_arr_rd_data; // RQ12
        rvalid_r[fidx] <= 1'b1;
      end
      if (tx_take && drd_r) begin
        buf_r[rsel_r] <= {buf_r[rsel_r][55:0], 8'h00};
        rcnt_r <= rcnt_r + 3'h1;
        if (rcnt_r == vsm_pkg::BYTE_LAST) begin
          rvalid_r[rsel_r] <= 1'b0;
          rsel_r <= ~rsel_r; // RQ12
        end
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_scl = 1'b0;
  assign o_scl_oe = hold_r; // RQ11
  assign o_sda = 1'b0;
  assign o_sda_oe = sda_oe_r;
  assign o_int = 1'b0;
  assign o_int_oe = int_mark_r | int_ovf_r; // RQ19
  assign o_row_boundary_strobe = 1'b0;
  assign o_row_boundary_strobe_oe = running &&
    blk_r == vsm_pkg::BLK_LAST; // RQ20
  assign o_arr_page = page_r;
  assign o_arr_blk = blk_r;
  assign o_arr_wr_valid = pend_r[~wsel_r];
  assign o_arr_wr_data = buf_r[~wsel_r];
  assign o_arr_rd_req = drd_r & ~(rvalid_r[0] & rvalid_r[1]);
  assign o_end_of_message_marker_wr = mark_stop;
  assign o_erase_req = erase_r;
  assign o_power_up = pwr_r;
  assign o_rec = rec_r;
  assign o_play = play_r;
  assign o_cfg0 = cfg0_r;
  assign o_cfg1 = cfg1_r;

  // ****************************************
  // Checks
  // ****************************************
  a_int_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_ce && o_int_oe && !status_clr |=> o_int_oe) // RQ19
    else $error("interrupt dropped without status read");
  a_int_cause: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $rose(o_int_oe) |-> $past(mark_play || wrap_ovf)) // RQ6
    else $error("interrupt without marker or overflow");
  a_addr_low_zero: assert property (@(posedge i_clk_sys)
    disable iff (i_reset) tx_take && !drd_r && ridx_r == vsm_pkg::RI_ALO
    |-> tx_byte[4:0] == vsm_pkg::ADDR_LOW_ZERO) // RQ21
    else $error("low address bits not zero");
  a_addr_ack: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_ce && !bus_start && !bus_stop && st_r == vsm_pkg::S_ADDR &&
    scl_fall && cnt_r == vsm_pkg::BITS_PER_BYTE && addr_match
    |=> st_r == vsm_pkg::S_AACK && o_sda_oe) // RQ13
    else $error("own address not acknowledged");
  a_tx_dir: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $rose(st_r == vsm_pkg::S_TX) |-> rw_r) // RQ14
    else $error("transmit on a write transfer");
  a_byte_ack: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_ce && rx_ev && !bus_start && !bus_stop |=> o_sda_oe) // RQ10
    else $error("data byte not acknowledged");
  a_stretch_free: assert property (@(posedge i_clk_sys)
    disable iff (i_reset) i_ce && st_r == vsm_pkg::S_RXW && !need_swap_r
    ##1 i_ce |-> ##1 !o_scl_oe) // RQ22
    else $error("clock held after buffer freed");
  a_buf_swap: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_ce && wr_take && wcnt_r == vsm_pkg::BYTE_LAST &&
    !pend_r[~wsel_r] |=> wsel_r != $past(wsel_r)) // RQ9
    else $error("full buffer not swapped");
  a_mark_group: assert property (@(posedge i_clk_sys)
    disable iff (i_reset) o_end_of_message_marker_wr |->
    blk_r[1:0] == vsm_pkg::GRP_LAST && stop_pend_r) // RQ5 RQ4
    else $error("marker outside group end");
  a_row_end: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_ce && o_row_boundary_strobe_oe && blk_tick |=>
    !o_row_boundary_strobe_oe && blk_r == 5'h00) // RQ20
    else $error("row strobe not released at page end");
  c_stretch: cover property (@(posedge i_clk_sys) $rose(o_scl_oe));
  c_mark: cover property (@(posedge i_clk_sys) o_end_of_message_marker_wr);
  c_status: cover property (@(posedge i_clk_sys) status_clr);
  c_rd_swap: cover property (@(posedge i_clk_sys) tx_take && drd_r &&
    rcnt_r == vsm_pkg::BYTE_LAST);
endmodule
`default_nettype wire

// ==== rtl/vsm_pkg.sv ====
`default_nettype none
package vsm_pkg;
  // ****************************************
  // Timebase
  // ****************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int SR_4K0_HZ = 4000;
  localparam int SR_5K3_HZ = 5300;
  localparam int SR_6K4_HZ = 6400;
  localparam int SR_8K0_HZ = 8000;
  localparam int DIV_4K0 = CLK_HZ / SR_4K0_HZ;
  localparam int DIV_5K3 = CLK_HZ / SR_5K3_HZ;
  localparam int DIV_6K4 = CLK_HZ / SR_6K4_HZ;
  localparam int DIV_8K0 = CLK_HZ / SR_8K0_HZ;
  localparam logic [1:0] RATE_8K0 = 2'h0;
  localparam logic [1:0] RATE_6K4 = 2'h1;
  localparam logic [1:0] RATE_5K3 = 2'h2;
  localparam logic [1:0] RATE_4K0 = 2'h3;
  localparam int GROUP_MS = 32;
  localparam int BLKS_PER_GRP = 4;
  localparam int BLK_SAMPLES = GROUP_MS * SR_8K0_HZ / 1000 / BLKS_PER_GRP;
  localparam logic [5:0] BLK_SAMP_LAST = 6'(BLK_SAMPLES - 1);
  // ****************************************
  // Array geometry
  // ****************************************
  localparam int PAGE_W = 11;
  localparam int BLK_W = 5;
  localparam int BUF_W = 64;
  localparam logic [4:0] BLK_LAST = 5'h1f;
  localparam logic [1:0] GRP_LAST = 2'h3;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [11:0] PAGES_MIN = 12'h100;
  localparam logic [4:0] ADDR_LOW_ZERO = 5'h00;
  // ****************************************
  // Serial bus and command byte
  // ****************************************
  localparam logic [4:0] BUS_ADDR_TOP = 5'h10;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int CMD_PU = 7;
  localparam int CMD_DAB = 6;
  localparam logic [2:0] FN_STOP = 3'h0;
  localparam logic [2:0] FN_PLAY = 3'h5;
  localparam logic [2:0] FN_REC = 3'h2;
  localparam logic [2:0] FN_CUE = 3'h7;
  localparam logic [2:0] FN_DRD = 3'h4;
  localparam logic [2:0] FN_DWR = 3'h1;
  localparam logic [2:0] FN_ERASE = 3'h2;
  localparam logic [2:0] RG_NONE = 3'h0;
  localparam logic [2:0] RG_ADDR = 3'h1;
  localparam logic [2:0] RG_CFG0 = 3'h2;
  localparam logic [2:0] RG_CFG1 = 3'h3;
  localparam logic [1:0] BI_CMD = 2'h0;
  localparam logic [1:0] BI_HI = 2'h1;
  localparam logic [1:0] BI_LO = 2'h2;
  localparam logic [1:0] BI_DATA = 2'h3;
  localparam logic [1:0] RI_STAT = 2'h0;
  localparam logic [1:0] RI_AHI = 2'h1;
  localparam logic [1:0] RI_ALO = 2'h2;
  localparam logic [1:0] RI_END = 2'h3;
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_AACK, S_RX, S_RXACK, S_RXW, S_TXW, S_TX, S_TXACK
  } vsm_st_t;
endpackage
`default_nettype wire

// ==== verif/vsm_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****
// Bus host: 8 system clocks per bit
// ****
module vsm_host_model (
  input wire logic i_clk_sys,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // Idle bus: both lines released
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Moves just after the edge
  task automatic tk(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  // One bit; released data reads back through the pull-up
  task automatic bt(input logic b, output logic r);
    o_sda = b;
    tk(2);
    o_scl = 1'b1;
    while (i_scl !== 1'b1) tk(1);
    tk(2);
    r = i_sda;
    o_scl = 1'b0;
    tk(4);
  endtask
  // Start (v=1) or stop (v=0)
  task automatic cond(input logic v);
    o_sda = v;
    tk(2);
    o_scl = 1'b1;
    while (i_scl !== 1'b1) tk(1);
    tk(4);
    o_sda = ~v;
    tk(4);
    o_scl = ~v;
    tk(2);
  endtask
  // Byte out or in, MSB first, then the ninth bit
  task automatic xb(input logic [7:0] d, input logic l,
                    output logic [7:0] q, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
    bt(l, r);
    a = ~r;
  endtask
endmodule
`default_nettype wire

// ==== verif/voice_store_memory_access_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****
// Bench
// ****
module voice_store_memory_access_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] sel;
  logic [1:0] dens;
  logic h_scl, h_sda, scl_oe, sda_oe, wr_v, wr_done;
  logic int_oe, rb, mk, erq, pwr, rec, play, rrq, end_of_message_marker = 1'b0;
  logic [4:0] blk;
  logic [15:0] cfg0, cfg1;
  wire logic [3:0] od;
  int rb_n = 0, mk_n = 0, er_n = 0, wn = 0;
  logic [10:0] o_pg, pg;
  logic [63:0] wr_d, w;
  logic [63:0] q[$];
  logic [7:0] b, hi, lo;
  logic a;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  int dly = 20;
  // Open-drain wiring with pull-ups
  wire logic scl = h_scl & ~scl_oe;
  wire logic sda = h_sda & ~sda_oe;
  always #20 clk = ~clk;
  vsm_host_model h (.i_clk_sys(clk), .i_scl(scl), .i_sda(sda),
    .o_scl(h_scl), .o_sda(h_sda));
  // Short sample divider keeps analog runs brief
  vsm_core #(.P_DIV_4K0(8)) dut (.i_clk_sys(clk), .i_reset(rst),
    .i_ce(1'b1), .i_scl(scl), .o_scl(od[3]), .o_scl_oe(scl_oe),
    .i_sda(sda), .o_sda(od[2]), .o_sda_oe(sda_oe),
    .i_addr_select_high(sel[1]), .i_addr_select_low(sel[0]),
    .i_density(dens), .o_int(od[1]), .o_int_oe(int_oe),
    .o_row_boundary_strobe(od[0]), .o_row_boundary_strobe_oe(rb),
    .o_arr_page(o_pg), .o_arr_blk(blk), .o_arr_wr_valid(wr_v),
    .o_arr_wr_data(wr_d), .i_arr_wr_done(wr_done), .o_arr_rd_req(rrq),
    .i_arr_rd_valid(1'b0), .i_arr_rd_data(64'h0),
    .i_end_of_message_marker(end_of_message_marker), .o_end_of_message_marker_wr(mk),
    .o_erase_req(erq), .o_power_up(pwr), .o_rec(rec), .o_play(play),
    .o_cfg0(cfg0), .o_cfg1(cfg1));
  task automatic end_sim();
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] e,
                     input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // Slow array: long random waits force the host to be held
  always @(posedge clk) begin
    #1;
    if (wr_v === 1'b1 && dly == 0) begin
      chk("wr_data", q.pop_front(), wr_d);
      chk("wr_page", 64'(pg), 64'(o_pg));
      chk("wr_blk", 64'(wn), 64'(blk));
      chk("rd_req", 64'h0, 64'(rrq));
      wn++;
      dly = $urandom_range(900, 20);
      wr_done = 1'b1;
    end else begin
      if (wr_v === 1'b1) dly--;
      wr_done = 1'b0;
    end
  end
  // Strobes and pulses counted mid-cycle
  always @(negedge clk) begin
    rb_n += int'(rb === 1'b1);
    mk_n += int'(mk === 1'b1);
    er_n += int'(erq === 1'b1);
  end
  // Command byte, then a two-byte word
  task automatic cmd3(input logic [7:0] c, input logic [15:0] v);
    h.cond(1'b1);
    h.xb(8'h86, 1'b1, b, a);
    h.xb(c, 1'b1, b, a);
    h.xb(v[15:8], 1'b1, b, a);
    h.xb(v[7:0], 1'b1, b, a);
    h.cond(1'b0);
  endtask
  // Status read: status byte, then the page address
  task automatic rd3(input logic [7:0] st, input logic [10:0] p);
    h.cond(1'b1);
    h.xb(8'h87, 1'b1, b, a);
    chk("ack_rd", 64'h1, 64'(a));
    h.xb(8'hff, 1'b0, b, a);
    h.xb(8'hff, 1'b0, hi, a);
    h.xb(8'hff, 1'b1, lo, a);
    h.cond(1'b0);
    chk("status", 64'(st), 64'(b));
    chk("addr_hi", 64'(p[10:3]), 64'(hi));
    chk("addr_lo", 64'({p[2:0], 5'h0}), 64'(lo));
    chk("int_clr", 64'h0, 64'(int_oe));
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      end_sim();
    end
  end
  // Main sequence
  initial begin
    void'($urandom(48448));
    sel = 2'h0;
    dens = 2'($urandom_range(3, 0));
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    for (int s = 0; s < 4; s++) begin
      sel = 2'(s);
      h.tk(6);
      h.cond(1'b1);
      h.xb(8'h80 | 8'(s * 2), 1'b1, b, a);
      chk("ack_own", 64'h1, 64'(a));
      h.cond(1'b0);
      h.cond(1'b1);
      h.xb(8'h80 | 8'(((s + 1) % 4) * 2), 1'b1, b, a);
      chk("ack_other", 64'h0, 64'(a));
      h.cond(1'b0);
    end
    pg = 11'($urandom) & 11'((256 << dens) - 1);
    h.cond(1'b1);
    h.xb(8'h86, 1'b1, b, a);
    h.xb(8'hc9, 1'b1, b, a);
    h.xb(pg[10:3], 1'b1, b, a);
    h.xb({pg[2:0], 5'h0}, 1'b1, b, a);
    for (int i = 0; i < 24; i++) begin
      b = 8'($urandom);
      w = {w[55:0], b};
      if (i % 8 == 7) q.push_back(w);
      h.xb(b, 1'b1, hi, a);
      chk("ack_data", 64'h1, 64'(a));
    end
    h.cond(1'b0);
    for (int i = 0; i < 3000 && q.size() > 0; i++) h.tk(1);
    chk("words_left", 64'h0, 64'(q.size()));
    cmd3(8'hd0, 16'h0000);
    rd3(8'h0c, pg);
    chk("erase", 64'h1, 64'(er_n));
    for (int r = 2; r < 4; r++) begin
      w = 64'($urandom | 3);
      cmd3(8'h80 | 8'(r), w[15:0]);
      chk("cfg", w[15:0], 64'(r == 2 ? cfg0 : cfg1));
    end
    // Record across the last page: row strobe, then overflow
    cmd3(8'h91, {11'((256 << dens) - 1), 5'h00});
    chk("rec_on", 64'h1, 64'(rec));
    h.tk(16500);
    chk("row_strobe", 64'(64 * 8), 64'(rb_n));
    chk("int_ovf", 64'h1, 64'(int_oe));
    rd3(8'h84, 11'h000);
    cmd3(8'h91, {pg, 5'h00});
    cmd3(8'h80, 16'h0000);
    h.tk(2100);
    chk("marker", 64'h1, 64'(mk_n));
    chk("rec_off", 64'h0, 64'(rec));
    end_of_message_marker = 1'b1;
    cmd3(8'ha9, {pg, 5'h00});
    chk("play_on", 64'h1, 64'(play));
    h.tk(2100);
    chk("play_off", 64'h0, 64'(play));
    chk("int_eom", 64'h1, 64'(int_oe));
    rd3(8'h44, pg);
    chk("pins", 64'h1, 64'({od, pwr}));
    end_sim();
  end
endmodule
`default_nettype wire
